// [ret_rot_pkg.sv]
// Shared constants for the return and rotate execution block
package ret_rot_pkg;
   localparam int DATA_W   = 8;
   localparam int ADDR_W   = 7;
   localparam int PC_W     = 15;
   localparam int DEPTH    = 16;
   localparam int SP_W     = 4;
   localparam int OP_W     = 3;
   localparam logic [OP_W-1:0] OP_NONE   = 3'h0;
   localparam logic [OP_W-1:0] OP_RETLIT = 3'h1;
   localparam logic [OP_W-1:0] OP_RETURN = 3'h2;
   localparam logic [OP_W-1:0] OP_RETIRQ = 3'h3;
   localparam logic [OP_W-1:0] OP_ROTL   = 3'h4;
   localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
   localparam logic [PC_W-1:0]   PC_RST  = 15'h0000;
   localparam logic [SP_W-1:0]   SP_RST  = 4'hf;
   localparam logic              DEST_ACC = 1'b0;
   localparam logic              DEST_REG = 1'b1;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FLUSH = 2'b01
   } exec_state_t;
endpackage : ret_rot_pkg

// [return_stack_mem.sv]
// Hardware return stack storage with registered read of the head entry
`timescale 1ns/1ps
module return_stack_mem
   import ret_rot_pkg::*;
(
   input  wire logic                  clk,      // Instruction cycle clock
   input  wire logic                  wrEn,     // Push write strobe
   input  wire logic [SP_W-1:0]       wrAddr,   // Push slot
   input  wire logic [PC_W-1:0]       wrData,   // Return address pushed
   input  wire logic [SP_W-1:0]       rdAddr,   // Slot to read
   output logic      [PC_W-1:0]       rdData    // Registered read data
);
   logic [PC_W-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule : return_stack_mem

// [return_and_rotate_exec.sv]
// Execution of literal return, plain and interrupt return, and rotate left
`timescale 1ns/1ps
module return_and_rotate_exec
   import ret_rot_pkg::*;
(
   input  wire logic                  clk,          // Instruction cycle clock
   input  wire logic                  rst_b,        // Async reset, active low
   input  wire logic                  instValid,    // Decoded instruction present
   input  wire logic [OP_W-1:0]       instOp,       // Decoded operation
   input  wire logic [DATA_W-1:0]     literal,      // Immediate operand
   input  wire logic [ADDR_W-1:0]     regSel,       // Register operand
   input  wire logic                  destSel,      // Destination selector
   input  wire logic [DATA_W-1:0]     regRdData,    // File register read data
   input  wire logic                  pushEn,       // Call pushes return address
   input  wire logic [PC_W-1:0]       pushAddr,     // Address to push
   output logic                       busy,         // Second cycle of a return
   output logic [DATA_W-1:0]          acc_ff,       // Accumulator
   output logic                       carry_ff,     // Carry flag
   output logic                       global_irq_enable, // Interrupt enable bit
   output logic                       pcLoad,       // Program counter load pulse
   output logic [PC_W-1:0]            pcValue,      // Program counter load value
   output logic [SP_W-1:0]            sp_ff,        // Stack pointer
   output logic                       regWrEn,      // File register write pulse
   output logic [ADDR_W-1:0]          regWrAddr,    // File register write address
   output logic [DATA_W-1:0]          regWrData     // File register write data
);
   import ret_rot_pkg::*;

   exec_state_t state_ff, nxt_state;
   logic [PC_W-1:0] stack_head;
   logic [SP_W-1:0] nxt_sp;
   logic            irqRet_ff;

   function automatic logic [DATA_W:0] rotl(input logic [DATA_W-1:0] v, input logic c);
      rotl = {v, c};
   endfunction : rotl

   wire accept   = instValid && state_ff == ST_IDLE;
   wire isRetLit = accept && instOp == OP_RETLIT;
   wire isRet    = accept && (instOp == OP_RETURN || instOp == OP_RETIRQ || instOp == OP_RETLIT);
   wire isRotl   = accept && instOp == OP_ROTL;
   wire [DATA_W:0] rotRes = rotl(regRdData, carry_ff);
   wire rdSp     = isRet;

   // A pop reads the head in the first cycle; the registered read lands for the second
   assign nxt_sp    = pushEn ? sp_ff + 4'h1 : (rdSp ? sp_ff - 4'h1 : sp_ff);
   assign nxt_state = isRet ? ST_FLUSH : ST_IDLE;

   return_stack_mem uStack (
      .clk    (clk),
      .wrEn   (pushEn),
      .wrAddr (sp_ff + 4'h1),
      .wrData (pushAddr),
      .rdAddr (sp_ff),
      .rdData (stack_head)
   );

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff  <= ST_IDLE;
         sp_ff     <= SP_RST;
         irqRet_ff <= 1'b0;
      end else begin
         state_ff  <= nxt_state;
         sp_ff     <= nxt_sp;
         irqRet_ff <= accept && instOp == OP_RETIRQ;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         acc_ff   <= ACC_RST;
         carry_ff <= 1'b0;
      end else if (isRetLit) begin
         acc_ff <= literal;
      end else if (isRotl) begin
         carry_ff <= rotRes[DATA_W];
         if (destSel == DEST_ACC) begin
            acc_ff <= rotRes[DATA_W-1:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         global_irq_enable <= 1'b0;
         pcLoad            <= 1'b0;
         pcValue           <= PC_RST;
         busy              <= 1'b0;
         regWrEn           <= 1'b0;
         regWrAddr         <= 7'h00;
         regWrData         <= 8'h00;
      end else begin
         busy    <= isRet;
         pcLoad  <= 1'b0;
         regWrEn <= isRotl && destSel == DEST_REG;
         if (isRotl) begin
            regWrAddr <= regSel;
            regWrData <= rotRes[DATA_W-1:0];
         end
         if (state_ff == ST_FLUSH) begin
            pcLoad  <= 1'b1;
            pcValue <= stack_head;
            if (irqRet_ff) begin
               global_irq_enable <= 1'b1;
            end
         end
      end
   end
endmodule : return_and_rotate_exec

// [return_and_rotate_exec_properties.sv]
// Assertions on the return and rotate execution block
`timescale 1ns/1ps
module return_and_rotate_exec_properties
   import ret_rot_pkg::*;
(input wire logic clk, rst_b, instValid, destSel, busy, carry_ff, pcLoad, regWrEn,
 input wire logic global_irq_enable,
 input wire logic [OP_W-1:0] instOp,
 input wire logic [DATA_W-1:0] literal, regRdData, acc_ff,
 input wire logic [SP_W-1:0] sp_ff);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire go  = instValid & ~busy;
   wire ret = go & (instOp == OP_RETLIT | instOp == OP_RETURN);
   wire rot = go & (instOp == OP_ROTL);
   property p_lit; go && instOp == OP_RETLIT |=> acc_ff == $past(literal); endproperty
   a_lit: assert property (p_lit) else $error("acc");
   property p_pc; ret |=> busy ##1 pcLoad && !busy; endproperty
   a_pc: assert property (p_pc) else $error("pc");
   property p_flg; ret |=> $stable(carry_ff) ##1 $stable(carry_ff); endproperty
   a_flg: assert property (p_flg) else $error("flag");
   property p_irq; go && instOp == OP_RETIRQ |-> ##2 global_irq_enable; endproperty
   a_irq: assert property (p_irq) else $error("irq");
   property p_cy; rot |=> carry_ff == $past(regRdData[7]) && !busy; endproperty
   a_cy: assert property (p_cy) else $error("carry");
   property p_acc; rot && destSel == DEST_ACC
      |=> acc_ff == {$past(regRdData[6:0]), $past(carry_ff)} && !regWrEn; endproperty
   a_acc: assert property (p_acc) else $error("rot acc");
   property p_wr; rot && destSel == DEST_REG |=> regWrEn; endproperty
   a_wr: assert property (p_wr) else $error("rot wr");
   property p_sp; ret |=> sp_ff == $past(sp_ff) - 4'h1; endproperty
   a_sp: assert property (p_sp) else $error("sp");
endmodule : return_and_rotate_exec_properties
bind return_and_rotate_exec return_and_rotate_exec_properties i_chk (.*);

// [tb.sv]
// Bench for the return and rotate execution block
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
   import ret_rot_pkg::*;
   logic clk = 0, rst_b = 0, instValid = 0, destSel = 0, pushEn = 0;
   logic [OP_W-1:0] instOp = OP_NONE;
   logic [DATA_W-1:0] literal = '0, regRdData = '0, acc_ff, regWrData;
   logic [ADDR_W-1:0] regSel = 7'h7f, regWrAddr;
   logic [PC_W-1:0] pushAddr = '0, pcValue;
   logic [SP_W-1:0] sp_ff;
   logic busy, carry_ff, global_irq_enable, pcLoad, regWrEn;
   int fail_count = 0, total_checks = 0;
   return_and_rotate_exec i_dut (.*);
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic issue(input logic [OP_W-1:0] o, input logic [DATA_W-1:0] k, r, input logic d);
      @(posedge clk) #1;
      instValid = 1;
      {instOp, literal, regRdData, destSel} = {o, k, r, d};
      @(posedge clk) #1;
      instValid = 0;
   endtask : issue
   task automatic push(input logic [PC_W-1:0] a);
      @(posedge clk) #1;
      {pushEn, pushAddr} = {1'b1, a};
      @(posedge clk) #1;
      pushEn = 0;
   endtask : push
   // The first rotate starts from the reset carry of zero, the second from the carry of one it leaves
   task automatic t_rot;
      issue(OP_ROTL, 8'h00, 8'he6, DEST_ACC);
      `CHK("acc", 8'hcc, acc_ff)
      `CHK("carry", 1'b1, carry_ff)
      `CHK("noWr", 1'b0, regWrEn)
      `CHK("rotBusy", 1'b0, busy)
      issue(OP_ROTL, 8'h00, 8'h81, DEST_REG);
      `CHK("wdata", 8'h03, regWrData)
      `CHK("wren", 1'b1, regWrEn)
      `CHK("accKept", 8'hcc, acc_ff)
      `CHK("waddr", 7'h7f, regWrAddr)
      $display("rotate done");
   endtask : t_rot
   task automatic t_ret(input logic [OP_W-1:0] o, input logic [DATA_W-1:0] k,
                        input logic [PC_W-1:0] a);
      logic [SP_W-1:0] s;
      s = sp_ff;
      issue(o, k, 8'h00, 1'b0);
      `CHK("sp", s - 4'h1, sp_ff)
      `CHK("busy", 1'b1, busy)
      `CHK("earlyLoad", 1'b0, pcLoad)
      if (o == OP_RETLIT) `CHK("acc", k, acc_ff)
      @(posedge clk) #1;
      `CHK("pcLoad", 1'b1, pcLoad)
      `CHK("busyEnd", 1'b0, busy)
      `CHK("pc", a, pcValue)
      `CHK("carry", 1'b1, carry_ff)
      `CHK("irq", o == OP_RETIRQ, global_irq_enable)
      $display("return %0d done", o);
   endtask : t_ret
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude
   initial begin
      repeat (8) @(posedge clk);
      #1 rst_b = 1;
      t_rot;
      push(15'h1234);
      push(15'h0abc);
      t_ret(OP_RETLIT, 8'hff, 15'h0abc);
      t_ret(OP_RETURN, 8'h00, 15'h1234);
      push(15'h7fff);
      t_ret(OP_RETIRQ, 8'h00, 15'h7fff);
      conclude;
   end
endmodule : tb
